// ===== src/radio_status_readback_bank.sv
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "radio_status_defs.svh"

module radio_status_readback_bank #(
    parameter int ADDR_W = 8
) (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire radio_status_pkg::radio_status_s radio_i,
    input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output logic irq_o
);

    // ****************************************************************
    // Packet status and interrupt events.
    // ****************************************************************
    logic crc_ok;
    logic next_crc_ok;
    logic [2:0] prev_level;
    logic [2:0] next_prev_level;
    logic [`IRQ_WIDTH-1:0] irq_status;
    logic [`IRQ_WIDTH-1:0] next_irq_status;
    logic [`IRQ_WIDTH-1:0] irq_mask;
    logic [`IRQ_WIDTH-1:0] next_irq_mask;
    logic [`IRQ_WIDTH-1:0] irq_event;
    logic [`IRQ_WIDTH-1:0] irq_clear;
    logic [7:0] pkt_status;

    // ****************************************************************
    // Register bus state.
    // ****************************************************************
    logic aw_full;
    logic next_aw_full;
    logic w_full;
    logic next_w_full;
    logic [5:0] aw_index;
    logic [5:0] next_aw_index;
    logic [7:0] w_byte;
    logic [7:0] next_w_byte;
    logic w_lane0;
    logic next_w_lane0;
    logic bvalid;
    logic next_bvalid;
    logic [1:0] bresp;
    logic [1:0] next_bresp;
    logic rvalid;
    logic next_rvalid;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic [1:0] rresp;
    logic [1:0] next_rresp;
    logic wr_do;
    logic rd_fire;
    logic [5:0] rd_index;

    // Bus handshakes; a held address or data word blocks its own channel.
    assign s_axi_awready_o = !aw_full;
    assign s_axi_wready_o = !w_full;
    assign s_axi_arready_o = !rvalid;
    assign s_axi_bvalid_o = bvalid;
    assign s_axi_bresp_o = bresp;
    assign s_axi_rvalid_o = rvalid;
    assign s_axi_rdata_o = rdata;
    assign s_axi_rresp_o = rresp;
    assign wr_do = aw_full && w_full && !bvalid;
    assign rd_fire = s_axi_arvalid_i && !rvalid;
    assign rd_index = s_axi_araddr_i[7:2];

    // Packet status byte; live bits pass straight from the radio core.
    always_comb begin
        pkt_status = {
            crc_ok,
            radio_i.carrier_sense,
            radio_i.preamble_quality_met,
            radio_i.clear_channel_flag,
            radio_i.sync_word_found,
            radio_i.general_output_pin_third,
            radio_i.general_output_pin_second,
            radio_i.general_output_pin_first
        };
    end

    // CRC flag: entering receive mode wins over a result in the same cycle.
    always_comb begin
        if (radio_i.rx_enter) begin
            next_crc_ok = 1'b0;
        end else if (radio_i.crc_check_done) begin
            next_crc_ok = radio_i.crc_match;
        end else begin
            next_crc_ok = crc_ok;
        end
    end

    // Rising edges of the sticky conditions and a CRC match raise interrupt events.
    always_comb begin
        next_prev_level = {radio_i.sync_word_found,
                           radio_i.transmit_queue_underrun,
                           radio_i.receive_queue_overrun};
        irq_event = '0;
        irq_event[`IRQ_CRC_BIT] = radio_i.crc_check_done &&
                                  radio_i.crc_match && !radio_i.rx_enter;
        irq_event[`IRQ_SYNC_BIT] = next_prev_level[2] && !prev_level[2];
        irq_event[`IRQ_TXUNDER_BIT] = next_prev_level[1] && !prev_level[1];
        irq_event[`IRQ_RXOVER_BIT] = next_prev_level[0] && !prev_level[0];
    end

    // Write-one-to-clear; a new event in the clearing cycle is kept.
    always_comb begin
        irq_clear = '0;
        next_irq_mask = irq_mask;
        if (wr_do && w_lane0 && aw_index == `IRQ_STATUS_IDX) begin
            irq_clear = w_byte[`IRQ_WIDTH-1:0];
        end
        if (wr_do && w_lane0 && aw_index == `IRQ_MASK_IDX) begin
            next_irq_mask = w_byte[`IRQ_WIDTH-1:0];
        end
        next_irq_status = (irq_status & ~irq_clear) | irq_event;
    end

    // Write channel: address and data are held until both are in.
    always_comb begin
        next_aw_full = aw_full;
        next_w_full = w_full;
        next_aw_index = aw_index;
        next_w_byte = w_byte;
        next_w_lane0 = w_lane0;
        next_bvalid = bvalid;
        next_bresp = bresp;
        if (s_axi_awvalid_i && !aw_full) begin
            next_aw_full = 1'b1;
            next_aw_index = s_axi_awaddr_i[7:2];
        end
        if (s_axi_wvalid_i && !w_full) begin
            next_w_full = 1'b1;
            next_w_byte = s_axi_wdata_i[7:0];
            next_w_lane0 = s_axi_wstrb_i[0];
        end
        if (bvalid && s_axi_bready_i) begin
            next_bvalid = 1'b0;
        end
        if (wr_do) begin
            next_aw_full = 1'b0;
            next_w_full = 1'b0;
            next_bvalid = 1'b1;
            unique case (aw_index)
                `WAKE_HI_IDX, `WAKE_LO_IDX, `PKT_STATUS_IDX,
                `SYNTH_DAC_IDX, `TX_LEVEL_IDX, `RX_LEVEL_IDX:
                    next_bresp = `AXI_SLVERR;
                `IRQ_STATUS_IDX, `IRQ_MASK_IDX: next_bresp = `AXI_OKAY;
                default: next_bresp = `AXI_DECERR;
            endcase
        end
    end

    // Read channel: data is captured in the cycle the address is taken.
    always_comb begin
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        if (rvalid && s_axi_rready_i) begin
            next_rvalid = 1'b0;
        end
        if (rd_fire) begin
            next_rvalid = 1'b1;
            next_rresp = `AXI_OKAY;
            next_rdata = 32'h0000_0000;
            unique case (rd_index)
                `WAKE_HI_IDX: next_rdata[7:0] = radio_i.wake_timer[15:8];
                `WAKE_LO_IDX: next_rdata[7:0] = radio_i.wake_timer[7:0];
                `PKT_STATUS_IDX: next_rdata[7:0] = pkt_status;
                `SYNTH_DAC_IDX: next_rdata[7:0] = radio_i.synth_dac;
                `TX_LEVEL_IDX: next_rdata[7:0] = {
                    radio_i.transmit_queue_underrun,
                    radio_i.transmit_queue_count};
                `RX_LEVEL_IDX: next_rdata[7:0] = {
                    radio_i.receive_queue_overrun,
                    radio_i.receive_queue_count};
                `IRQ_STATUS_IDX: next_rdata[`IRQ_WIDTH-1:0] = irq_status;
                `IRQ_MASK_IDX: next_rdata[`IRQ_WIDTH-1:0] = irq_mask;
                default: next_rresp = `AXI_DECERR;
            endcase
        end
    end

    // All state registers; reset loads constants only.
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            crc_ok <= 1'b0;
            prev_level <= 3'h0;
            irq_status <= '0;
            irq_mask <= `IRQ_MASK_RESET;
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_index <= 6'h00;
            w_byte <= 8'h00;
            w_lane0 <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `AXI_OKAY;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `AXI_OKAY;
            irq_o <= 1'b0;
        end else begin
            crc_ok <= next_crc_ok;
            prev_level <= next_prev_level;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            aw_full <= next_aw_full;
            w_full <= next_w_full;
            aw_index <= next_aw_index;
            w_byte <= next_w_byte;
            w_lane0 <= next_w_lane0;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
            irq_o <= |(next_irq_status & next_irq_mask);
        end
    end

    // ****************************************************************
    // Checks on the readback and the flags.
    // ****************************************************************
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!reset_n_i);

    a_crc_rx_clear: assert property (
        radio_i.rx_enter |=> !crc_ok && pkt_status[`PKT_CRC_BIT] == 1'b0)
        else $error("CRC flag survived receive entry");
    a_crc_match_set: assert property (
        radio_i.crc_check_done && radio_i.crc_match && !radio_i.rx_enter
        |=> crc_ok)
        else $error("CRC flag not set after match");
    a_wake_high_read: assert property (
        rd_fire && rd_index == `WAKE_HI_IDX
        |=> rvalid && rdata == {24'h000000, $past(radio_i.wake_timer[15:8])})
        else $error("Wake timer high byte wrong");
    a_wake_low_read: assert property (
        rd_fire && rd_index == `WAKE_LO_IDX
        |=> rdata == {24'h000000, $past(radio_i.wake_timer[7:0])})
        else $error("Wake timer low byte wrong");
    a_pkt_live_read: assert property (
        rd_fire && rd_index == `PKT_STATUS_IDX
        |=> rdata[6:3] == $past({radio_i.carrier_sense,
            radio_i.preamble_quality_met, radio_i.clear_channel_flag,
            radio_i.sync_word_found}) && rdata[7] == $past(crc_ok))
        else $error("Packet status live bits wrong");
    a_pkt_pins_read: assert property (
        rd_fire && rd_index == `PKT_STATUS_IDX
        |=> rdata[2:0] == $past({radio_i.general_output_pin_third,
            radio_i.general_output_pin_second,
            radio_i.general_output_pin_first}))
        else $error("Packet status pin bits wrong");
    a_tx_level_read: assert property (
        rd_fire && rd_index == `TX_LEVEL_IDX
        |=> rdata[`QUEUE_FLAG_BIT] == $past(radio_i.transmit_queue_underrun)
            && rdata[6:0] == $past(radio_i.transmit_queue_count))
        else $error("Transmit status wrong");
    a_rx_level_read: assert property (
        rd_fire && rd_index == `RX_LEVEL_IDX
        |=> rdata[`QUEUE_FLAG_BIT] == $past(radio_i.receive_queue_overrun)
            && rdata[6:0] == $past(radio_i.receive_queue_count))
        else $error("Receive status wrong");
    a_dac_read: assert property (
        rd_fire && rd_index == `SYNTH_DAC_IDX
        |=> rdata == {24'h000000, $past(radio_i.synth_dac)})
        else $error("Calibration DAC readback wrong");
    a_ro_write_ignored: assert property (
        wr_do && aw_index >= `WAKE_HI_IDX && aw_index <= `RX_LEVEL_IDX
        |=> $stable(irq_mask) && bresp == `AXI_SLVERR && bvalid)
        else $error("Write to status bank had an effect");
    a_sticky_set_wins: assert property (
        irq_event[`IRQ_SYNC_BIT] |=> irq_status[`IRQ_SYNC_BIT])
        else $error("Interrupt event lost");
    a_irq_follows_mask: assert property (
        irq_o == |(irq_status & irq_mask))
        else $error("Interrupt output disagrees with status and mask");

    c_pkt_read: cover property (rd_fire && rd_index == `PKT_STATUS_IDX);
    c_ro_write: cover property (wr_do && aw_index == `TX_LEVEL_IDX);
    c_irq_rise: cover property (!irq_o ##1 irq_o);
    c_crc_then_rx: cover property (crc_ok ##1 radio_i.rx_enter ##1 !crc_ok);

endmodule
`default_nettype wire

// ===== pkg/radio_status_defs.svh
`ifndef RADIO_STATUS_DEFS_SVH
`define RADIO_STATUS_DEFS_SVH
// Overview of operation
// - The wake timer reads as a high byte and, one index later, a low byte.
// - Bit 7 of packet status shows the last CRC match, cleared on RX entry.
// - Packet status bits 6..3 show carrier, preamble, clear channel, sync.
// - Packet status bits 2..0 show the third, second and first output pins.
// - Transmit status gives the byte count in 6..0 and underrun in bit 7.
// - Receive status gives the byte count in 6..0 and overrun in bit 7.
// - The synthesizer calibration DAC setting reads as an 8-bit test value.

// ********************************************************************
// Register indices; the byte address is four times the index.
// ********************************************************************
`define WAKE_HI_IDX 6'h36
`define WAKE_LO_IDX 6'h37
`define PKT_STATUS_IDX 6'h38
`define SYNTH_DAC_IDX 6'h39
`define TX_LEVEL_IDX 6'h3A
`define RX_LEVEL_IDX 6'h3B
`define IRQ_STATUS_IDX 6'h3C
`define IRQ_MASK_IDX 6'h3D

// ********************************************************************
// Field positions and reset values.
// ********************************************************************
`define PKT_CRC_BIT 7
`define QUEUE_FLAG_BIT 7
`define IRQ_CRC_BIT 0
`define IRQ_SYNC_BIT 1
`define IRQ_TXUNDER_BIT 2
`define IRQ_RXOVER_BIT 3
`define IRQ_WIDTH 4
`define IRQ_MASK_RESET 4'h0
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2
`define AXI_DECERR 2'h3
`endif

// ===== pkg/radio_status_pkg.sv
package radio_status_pkg;
    // Live conditions from the radio core, all on the system clock.
    typedef struct packed {
        logic [15:0] wake_timer;
        logic crc_check_done;
        logic crc_match;
        logic rx_enter;
        logic carrier_sense;
        logic preamble_quality_met;
        logic clear_channel_flag;
        logic sync_word_found;
        logic general_output_pin_third;
        logic general_output_pin_second;
        logic general_output_pin_first;
        logic [7:0] synth_dac;
        logic transmit_queue_underrun;
        logic [6:0] transmit_queue_count;
        logic receive_queue_overrun;
        logic [6:0] receive_queue_count;
    } radio_status_s;
endpackage

// ===== verif/tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "radio_status_defs.svh"

module tb;
    logic clock;
    logic reset_n;
    radio_status_pkg::radio_status_s radio;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, got;
    logic [3:0] wstrb;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, irq, crc_exp;
    logic [1:0] bresp, rresp, resp;
    logic [6:0] live;
    logic [2:0] steps [6] = '{3'b110, 3'b111, 3'b110, 3'b010, 3'b110, 3'b001};
    int n_mismatch = 0;
    int cmp_count = 0;

    radio_status_readback_bank radio_status_readback_bank_inst (
        .clock_i(clock), .reset_n_i(reset_n), .radio_i(radio),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .irq_o(irq));

    // ********
    // Clock, checking and bus tasks.
    // ********
    // A 50 ns period gives the 20 MHz system clock.
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic end_sim();
        $display("counts: %0d compares, %0d mismatches", cmp_count,
            n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch at %0t: value %h expected %h", $time, g, e);
        end
    endtask

    task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch at %0t: resp %h expected %h", $time, g, e);
        end
    endtask

    // Ready is looked at on the falling edge, so the decision made at the
    // next rising edge never races with the design's own updates there.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_p, w_p, ta, tw;
        aw_p = 1'b1;
        w_p = 1'b1;
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (aw_p || w_p) begin
            @(negedge clock);
            ta = aw_p && (awready === 1'b1);
            tw = w_p && (wready === 1'b1);
            @(posedge clock);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            aw_p = aw_p && !ta;
            w_p = w_p && !tw;
        end
        do @(negedge clock); while (bvalid !== 1'b1);
        resp = bresp;
        @(posedge clock);
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a);
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge clock); while (arready !== 1'b1);
        @(posedge clock);
        arvalid <= 1'b0;
        do @(negedge clock); while (rvalid !== 1'b1);
        got = rdata;
        resp = rresp;
        @(posedge clock);
        rready <= 1'b0;
    endtask

    // Expected word of a status register, built from the driven conditions.
    function automatic logic [31:0] exp_of(input logic [5:0] idx);
        logic [7:0] v;
        case (idx)
            `WAKE_HI_IDX: v = radio.wake_timer[15:8];
            `WAKE_LO_IDX: v = radio.wake_timer[7:0];
            `PKT_STATUS_IDX: v = {crc_exp, live};
            `SYNTH_DAC_IDX: v = radio.synth_dac;
            `TX_LEVEL_IDX: v = {radio.transmit_queue_underrun,
                radio.transmit_queue_count};
            default: v = {radio.receive_queue_overrun,
                radio.receive_queue_count};
        endcase
        return {24'h0, v};
    endfunction

    task automatic read_bank();
        for (logic [5:0] i = `WAKE_HI_IDX; i <= `RX_LEVEL_IDX; i++) begin
            axi_rd({i, 2'b00});
            chk_val(got, exp_of(i));
            chk_resp(resp, `AXI_OKAY);
        end
    endtask

    task automatic set_live(input logic [6:0] v);
        @(posedge clock);
        live <= v;
        {radio.carrier_sense, radio.preamble_quality_met,
            radio.clear_channel_flag, radio.sync_word_found,
            radio.general_output_pin_third, radio.general_output_pin_second,
            radio.general_output_pin_first} <= v;
    endtask

    task automatic pulse(input logic m, input logic d, input logic e);
        @(posedge clock);
        radio.crc_match <= m;
        radio.crc_check_done <= d;
        radio.rx_enter <= e;
        @(posedge clock);
        radio.crc_check_done <= 1'b0;
        radio.rx_enter <= 1'b0;
        crc_exp = e ? 1'b0 : (d ? m : crc_exp);
    endtask

    // Event b of the interrupt status; only rising levels count, so the
    // other levels are dropped at the same time.
    task automatic ev(input int b);
        if (b == 0) pulse(1'b1, 1'b1, 1'b0);
        @(posedge clock);
        radio.sync_word_found <= (b == 1);
        radio.transmit_queue_underrun <= (b == 2);
        radio.receive_queue_overrun <= (b == 3);
    endtask

    // Watchdog; the whole sequence needs far fewer cycles than this.
    initial begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        $display("mismatch at %0t: watchdog expired", $time);
        end_sim();
    end

    // ********
    // Test sequence.
    // ********
    initial begin
        {awaddr, araddr, wdata, awvalid, wvalid, bready} = '0;
        {arvalid, rready, radio, live} = '0;
        wstrb = 4'hF;
        crc_exp = 1'b0;
        reset_n = 1'b0;
        repeat (8) @(posedge clock);
        reset_n <= 1'b1;
        pulse(1'b0, 1'b0, 1'b1);
        radio.wake_timer <= 16'hA53C;
        radio.synth_dac <= 8'h96;
        {radio.transmit_queue_underrun, radio.transmit_queue_count} <= 8'hC0;
        {radio.receive_queue_overrun, radio.receive_queue_count} <= 8'h7F;
        read_bank();
        radio.wake_timer <= 16'h5AC3;
        radio.synth_dac <= 8'h69;
        {radio.transmit_queue_underrun, radio.transmit_queue_count} <= 8'h00;
        {radio.receive_queue_overrun, radio.receive_queue_count} <= 8'h81;
        read_bank();
        $display("test fields done");
        for (int i = 0; i < 8; i++) begin
            set_live((i < 7) ? 7'(1 << i) : 7'h7F);
            axi_rd({`PKT_STATUS_IDX, 2'b00});
            chk_val(got, exp_of(`PKT_STATUS_IDX));
        end
        $display("test live bits done");
        for (int i = 0; i < 6; i++) begin
            pulse(steps[i][2], steps[i][1], steps[i][0]);
            axi_rd({`PKT_STATUS_IDX, 2'b00});
            chk_val(got, exp_of(`PKT_STATUS_IDX));
        end
        $display("test crc flag done");
        for (logic [5:0] i = `WAKE_HI_IDX; i <= `RX_LEVEL_IDX; i++) begin
            axi_wr({i, 2'b00}, 32'hFFFFFFFF);
            chk_resp(resp, `AXI_SLVERR);
        end
        read_bank();
        axi_wr(8'h00, 32'hFFFFFFFF);
        chk_resp(resp, `AXI_DECERR);
        for (int i = 0; i < 2; i++) begin
            axi_rd(i == 0 ? 8'h00 : 8'hFC);
            chk_val(got, 32'h0);
            chk_resp(resp, `AXI_DECERR);
        end
        $display("test writes done");
        axi_rd({`IRQ_MASK_IDX, 2'b00});
        chk_val(got, {28'h0, `IRQ_MASK_RESET});
        ev(2);
        repeat (2) @(posedge clock);
        chk_val({31'h0, irq}, 32'h0);
        axi_wr({`IRQ_STATUS_IDX, 2'b00}, 32'hF);
        for (int b = 0; b < 4; b++) begin
            axi_wr({`IRQ_MASK_IDX, 2'b00}, 32'(1 << b));
            ev(b);
            repeat (2) @(posedge clock);
            chk_val({31'h0, irq}, 32'h1);
            axi_rd({`IRQ_STATUS_IDX, 2'b00});
            chk_val(got, 32'(1 << b));
            axi_wr({`IRQ_STATUS_IDX, 2'b00}, 32'(1 << b));
            repeat (2) @(posedge clock);
            chk_val({31'h0, irq}, 32'h0);
            axi_rd({`IRQ_STATUS_IDX, 2'b00});
            chk_val(got, 32'h0);
        end
        // Byte lane 0 off: the mask keeps the value of the last loop pass.
        wstrb <= 4'hE;
        axi_wr({`IRQ_MASK_IDX, 2'b00}, 32'hF);
        chk_resp(resp, `AXI_OKAY);
        wstrb <= 4'hF;
        axi_rd({`IRQ_MASK_IDX, 2'b00});
        chk_val(got, 32'h8);
        $display("test interrupts done");
        end_sim();
    end
endmodule
`default_nettype wire
